// file: hdl/sae_pkg.sv
// Package for the stack-machine ALU and branch execution block.
// Assumes a 16-bit program word and a 33-bit top register, bit 16 = carry.
package sae_pkg;
  localparam int unsigned SAE_WORD_W = 16;
  localparam int unsigned SAE_TOP_W = 33;
  localparam int unsigned SAE_PC_W = 16;
  localparam int unsigned SAE_CARRY_BIT = 16;
  localparam int unsigned SAE_DIV_BIT = 31;
  localparam int unsigned SAE_BR_FIELD_W = 10;
  localparam int unsigned SAE_CALL_FIELD_W = 15;
  localparam logic [4:0] SAE_OP_COM = 5'h10;
  localparam logic [4:0] SAE_OP_AND = 5'h15;
  localparam logic [4:0] SAE_OP_DIV = 5'h16;
  localparam logic [4:0] SAE_OP_ADD = 5'h17;
  localparam logic [4:0] SAE_LONG_JUMP_ALWAYS = 5'h00;
  localparam logic [4:0] SAE_LONG_BRANCH_IF_ZERO = 5'h02;
  localparam logic [4:0] SAE_LONG_BRANCH_IF_CARRY = 5'h03;
  localparam logic [32:0] SAE_TOP_RST = 33'h0;
  localparam logic [15:0] SAE_A_RST = 16'h0;
  localparam logic [15:0] SAE_PC_RST = 16'h0;

  typedef struct packed {
    logic valid;
    logic first_slot;
    logic short_op;
    logic [4:0] code;
    logic [15:0] word;
  } sae_instr_t;

  typedef struct packed {
    logic pop_ps;
    logic push_rs;
    logic [15:0] rs_data;
  } sae_stack_t;
endpackage

// file: hdl/sae_exec.sv
// Execution unit: ADD, AND, COM, divide step, branches and call.
// Assumes the sequencer hands one instruction per cycle with slot info and
// the stacks supply the second-of-stack value combinationally.
//
// Overview of operation
// [RL1] Opcode 23 pops second and adds into top
// [RL2] Opcode 21 ANDs second into all 33 bits
// [RL3] Branch-if-carry jumps in page when carry set
// [RL4] Branch-if-carry always pops stack into top
// [RL5] Jump-always branches in page, nothing else changes
// [RL6] Branches and calls only in first slot
// [RL7] Branch-if-zero jumps when top zero, always pops
// [RL8] MSB zero word calls 15-bit field target
// [RL9] Call pushes next word address to return stack
// [RL10] Software does far jumps via return stack
// [RL11] Opcode 16 complements all 33 top bits
// [RL12] Divide step adds on carry, shifts pair left
// [RL13] Divide carry from top or adder bit 31
// [RL14] Software issues divide step 33 times
// [RL15] Targets replace only low program counter bits
`timescale 1ns/1ps
`default_nettype none
module sae_exec
  import sae_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire sae_instr_t i_instr,
  input wire logic [15:0] i_second,
  output logic [32:0] o_top,
  output logic [15:0] o_areg,
  output logic [15:0] o_pc,
  output sae_stack_t o_stack,
  output logic o_branch_taken
);

  logic [32:0] top_r;
  logic [32:0] top_nxt;
  logic [15:0] a_r;
  logic [15:0] a_nxt;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic taken_r;
  sae_stack_t stack_r;
  sae_stack_t stack_nxt;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire logic [32:0] second_ext = {17'h0, i_second};
  // Add works on the 16-bit data part only; bit 16 of the sum is the carry
  wire logic [32:0] sum = {17'h0, top_r[15:0]} + {17'h0, i_second};
  wire logic [32:0] add_res = {16'h0, sum[16:0]};
  wire logic is_long = i_instr.valid && !i_instr.short_op &&
                       i_instr.first_slot; // RL6
  wire logic is_call = is_long && !i_instr.word[15]; // RL8
  wire logic is_lbr = is_long && i_instr.word[15];
  wire logic [4:0] lcode = i_instr.word[14:10];
  wire logic do_jmp = is_lbr && (lcode == SAE_LONG_JUMP_ALWAYS); // RL5
  wire logic do_bz = is_lbr && (lcode == SAE_LONG_BRANCH_IF_ZERO); // RL7
  wire logic do_bc = is_lbr && (lcode == SAE_LONG_BRANCH_IF_CARRY); // RL3
  wire logic top_zero = (top_r[15:0] == 16'h0);
  wire logic carry = top_r[SAE_CARRY_BIT];
  wire logic take = do_jmp || (do_bz && top_zero) || (do_bc && carry);
  wire logic is_short = i_instr.valid && i_instr.short_op;
  // Page-relative targets keep upper program counter bits
  wire logic [15:0] br_tgt = {pc_r[15:10], i_instr.word[9:0]}; // RL15
  wire logic [15:0] call_tgt = {pc_r[15], i_instr.word[14:0]}; // RL15
  wire logic [15:0] pc_inc = pc_r + 16'h1;
  // Divide step: trial sum uses full 32-bit top, carry out at bit 32
  wire logic [32:0] div_sum = {1'b0, top_r[31:0]} + second_ext;
  wire logic div_add = div_sum[32]; // RL12
  wire logic [31:0] div_t = div_add ? div_sum[31:0] : top_r[31:0];
  wire logic div_c = div_add ? div_sum[31] : top_r[31]; // RL13

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    top_nxt = top_r;
    a_nxt = a_r;
    pc_nxt = pc_r;
    stack_nxt = '0;
    if (is_short) begin
      case (i_instr.code)
        SAE_OP_ADD: begin
          top_nxt = add_res; // RL1
          stack_nxt.pop_ps = 1'b1;
        end
        SAE_OP_AND: begin
          top_nxt = top_r & second_ext; // RL2
          stack_nxt.pop_ps = 1'b1;
        end
        SAE_OP_COM: top_nxt = ~top_r; // RL11
        SAE_OP_DIV: begin
          // Shift T-A left, carry into A(0)
          top_nxt = {div_c, div_t[30:0], a_r[15]}; // RL12
          a_nxt = {a_r[14:0], div_c};
        end
        default: top_nxt = top_r;
      endcase
    end else if (is_call) begin
      pc_nxt = call_tgt; // RL8
      stack_nxt.push_rs = 1'b1; // RL9
      stack_nxt.rs_data = pc_inc;
    end else if (is_lbr) begin
      if (take) begin
        pc_nxt = br_tgt;
      end
      if (do_bz || do_bc) begin
        top_nxt = second_ext; // RL4
        stack_nxt.pop_ps = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      top_r <= SAE_TOP_RST;
      a_r <= SAE_A_RST;
      pc_r <= SAE_PC_RST;
      stack_r <= '0;
      taken_r <= 1'b0;
    end else begin
      top_r <= top_nxt;
      a_r <= a_nxt;
      pc_r <= pc_nxt;
      stack_r <= stack_nxt;
      taken_r <= (is_lbr && take) || is_call;
    end
  end

  assign o_top = top_r;
  assign o_areg = a_r;
  assign o_pc = pc_r;
  assign o_stack = stack_r;
  assign o_branch_taken = taken_r;

  // ---------------------------------------------------------------
  // Checks: arithmetic and logic
  // ---------------------------------------------------------------
  add_result_a: assert property ( // RL1
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_ADD |=> o_stack.pop_ps &&
    o_top == {16'h0, $past(sum[16:0])}) else $error("add wrong");

  add_carry_a: assert property ( // RL1
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_ADD |=> o_top[16] ==
    (({1'b0, $past(top_r[15:0])} + {1'b0, $past(i_second)}) > 17'hffff))
    else $error("add carry wrong");

  add_low_a: assert property ( // RL1
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_ADD |=>
    o_top[15:0] == $past(top_r[15:0]) + $past(i_second))
    else $error("add data wrong");

  add_clear_a: assert property ( // RL1
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_ADD |=> o_top[32:17] == 16'h0)
    else $error("add upper bits set");

  and_result_a: assert property ( // RL2
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_AND |=>
    o_top == ($past(top_r) & $past(second_ext))) else $error("and wrong");

  and_pop_a: assert property ( // RL2
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_AND |=> o_stack.pop_ps &&
    !o_stack.push_rs) else $error("and pop wrong");

  // Second has no bit 16, so the carry always clears
  and_carry_a: assert property ( // RL2
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_AND |=> o_top[32:16] == 17'h0)
    else $error("and carry wrong");

  com_invert_a: assert property ( // RL11
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_COM |=> o_top == ~$past(top_r) &&
    !o_stack.pop_ps) else $error("com");

  com_areg_a: assert property ( // RL11
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_COM |=> $stable(o_areg) &&
    !o_stack.push_rs) else $error("com touched pair");

  // ---------------------------------------------------------------
  // Checks: divide step
  // ---------------------------------------------------------------
  div_shift_a: assert property ( // RL12
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_DIV |=>
    o_areg == {$past(a_r[14:0]), $past(div_c)}) else $error("div");

  div_carry_a: assert property ( // RL13
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_DIV |=> o_top[32] ==
    ($past(div_sum[32]) ? $past(div_sum[31]) : $past(top_r[31])))
    else $error("div carry wrong");

  div_noadd_a: assert property ( // RL12
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_DIV && !div_sum[32] |=>
    o_top[31:1] == $past(top_r[30:0])) else $error("div kept top");

  div_add_a: assert property ( // RL12
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_DIV && div_sum[32] |=>
    o_top[31:1] == $past(div_sum[30:0])) else $error("div added top");

  div_pair_a: assert property ( // RL12
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short && i_instr.code == SAE_OP_DIV |=> o_top[0] ==
    $past(a_r[15]) && !o_stack.pop_ps) else $error("div pair shift");

  // ---------------------------------------------------------------
  // Checks: branches and calls
  // ---------------------------------------------------------------
  carry_branch_a: assert property ( // RL3
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    do_bc && carry |=> o_pc == $past(br_tgt) && o_branch_taken)
    else $error("bc target");

  carry_hold_a: assert property ( // RL3
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    do_bc && !carry |=> o_pc == $past(pc_r) && !o_branch_taken)
    else $error("bc taken without carry");

  carry_pop_a: assert property ( // RL4
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    do_bc |=> o_stack.pop_ps && o_top == $past(second_ext))
    else $error("bc pop");

  jump_keep_a: assert property ( // RL5
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    do_jmp |=> $stable(o_top) && !o_stack.pop_ps && o_pc[15:10] ==
    $past(pc_r[15:10])) else $error("jump");

  jump_take_a: assert property ( // RL5
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    do_jmp |=> o_pc[9:0] == $past(i_instr.word[9:0]) && o_branch_taken)
    else $error("jump target");

  jump_stack_a: assert property ( // RL5
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    do_jmp |=> !o_stack.push_rs && $stable(o_areg))
    else $error("jump touched stacks");

  slot_only_a: assert property ( // RL6
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    i_instr.valid && !i_instr.short_op && !i_instr.first_slot |=>
    $stable(o_pc)) else $error("slot");

  slot_quiet_a: assert property ( // RL6
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    i_instr.valid && !i_instr.short_op && !i_instr.first_slot |=>
    !o_branch_taken && !o_stack.pop_ps && $stable(o_top))
    else $error("late slot acted");

  short_pc_a: assert property ( // RL6
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_short |=> $stable(o_pc) && !o_stack.push_rs && !o_branch_taken)
    else $error("short op moved flow");

  zero_branch_a: assert property ( // RL7
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    do_bz && !top_zero |=> o_pc == $past(pc_r) && o_stack.pop_ps)
    else $error("bz");

  zero_take_a: assert property ( // RL7
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    do_bz && top_zero |=> o_pc == $past(br_tgt) && o_branch_taken)
    else $error("bz target");

  zero_pop_a: assert property ( // RL7
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    do_bz |=> o_top == {17'h0, $past(i_second)})
    else $error("bz pop");

  call_flag_a: assert property ( // RL8
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_call |=> o_branch_taken && !o_stack.pop_ps && $stable(o_top))
    else $error("call side effect");

  call_push_a: assert property ( // RL9
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_call |=> o_stack.push_rs && o_stack.rs_data == $past(pc_r) + 16'h1 &&
    o_pc[14:0] == $past(i_instr.word[14:0])) else $error("call");

  push_only_a: assert property ( // RL9
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !is_call |=> !o_stack.push_rs) else $error("push without call");

  call_page_a: assert property ( // RL15
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_call |=> o_pc[15] == $past(pc_r[15])) else $error("call page");

  branch_page_a: assert property ( // RL15
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    is_lbr |=> o_pc[15:10] == $past(pc_r[15:10]))
    else $error("branch page");
endmodule
`default_nettype wire

// file: verif/sae_prog_mem.sv
// Program memory model that supplies 16-bit instruction words.
// Assumes the bench loads a word before the core executes it.
`timescale 1ns/1ps
`default_nettype none
module sae_prog_mem (
  input wire logic i_ref_clk,
  input wire logic i_we,
  input wire logic [15:0] i_waddr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_addr,
  output logic [15:0] o_word
);
  logic [15:0] mem [0:1023];
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr[9:0]] <= i_wdata;
    end
  end
  // Only one page modelled; addresses outside it alias onto its 1024 words
  assign o_word = mem[i_addr[9:0]];
endmodule
`default_nettype wire

// file: verif/sae_exec_tb.sv
// Bench for the execution unit: one task per scenario.
// Assumes outputs answer one cycle after a valid instruction.
`timescale 1ns/1ps
`default_nettype none
module stack_cpu_alu_branch_exec_tb;
  import sae_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  sae_instr_t instr = '0;
  logic [15:0] second = 16'h0;
  logic [15:0] ld_word = 16'h0;
  logic [15:0] exp_pc = 16'h0;
  logic we = 1'b0;
  logic [32:0] top;
  logic [15:0] pc, word;
  logic [15:0] areg;
  sae_stack_t stk;
  logic taken;
  int n_mismatch = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  sae_exec dut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_instr(instr),
    .i_second(second), .o_top(top), .o_areg(areg), .o_pc(pc),
    .o_stack(stk), .o_branch_taken(taken));
  sae_prog_mem mem (.i_ref_clk(clk), .i_we(we), .i_waddr(exp_pc),
    .i_wdata(ld_word), .i_addr(pc), .o_word(word));
  task automatic chk_vec(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic op(input logic [4:0] code, input logic [15:0] s);
    @(posedge clk) #1;
    instr = '{1'b1, 1'b0, 1'b1, code, 16'h0};
    second = s;
    @(posedge clk) #1;
    instr.valid = 1'b0;
  endtask
  // Word is fetched from memory, as the core would see it
  task automatic lng(input logic [15:0] w, input logic s1,
    input logic [15:0] s);
    @(posedge clk) #1;
    ld_word = w;
    we = 1'b1;
    @(posedge clk) #1;
    we = 1'b0;
    instr = '{1'b1, s1, 1'b0, w[14:10], word};
    second = s;
    @(posedge clk) #1;
    instr.valid = 1'b0;
  endtask
  task automatic flow(input logic [15:0] pc_e, input logic tk,
    input logic pop);
    chk_vec(pc, pc_e);
    chk_bit(taken, tk);
    chk_bit(stk.pop_ps, pop);
  endtask
  task automatic t_add;
    op(SAE_OP_ADD, 16'hffff);
    chk_vec(top, 33'h0ffff);
    chk_bit(stk.pop_ps, 1'b1);
    op(SAE_OP_ADD, 16'h0001);
    chk_vec(top, 33'h10000);
  endtask
  task automatic t_call;
    lng(16'h1234, 1'b1, 16'h0);
    chk_vec(pc, 16'h1234);
    chk_bit(stk.push_rs, 1'b1);
    chk_vec(stk.rs_data, exp_pc + 16'h1);
    exp_pc = 16'h1234;
  endtask
  task automatic t_bc;
    lng({1'b1, SAE_LONG_BRANCH_IF_CARRY, 10'h155}, 1'b1, 16'h0);
    exp_pc = {exp_pc[15:10], 10'h155};
    flow(exp_pc, 1'b1, 1'b1);
    chk_vec(top, 33'h0);
    lng({1'b1, SAE_LONG_BRANCH_IF_CARRY, 10'h0aa}, 1'b1, 16'h0);
    flow(exp_pc, 1'b0, 1'b1);
  endtask
  task automatic t_bz;
    lng({1'b1, SAE_LONG_BRANCH_IF_ZERO, 10'h3ff}, 1'b1, 16'h5);
    exp_pc = {exp_pc[15:10], 10'h3ff};
    flow(exp_pc, 1'b1, 1'b1);
    chk_vec(top, 33'h5);
    lng({1'b1, SAE_LONG_BRANCH_IF_ZERO, 10'h001}, 1'b1, 16'h0);
    flow(exp_pc, 1'b0, 1'b1);
  endtask
  task automatic t_jmp;
    lng({1'b1, SAE_LONG_JUMP_ALWAYS, 10'h200}, 1'b1, 16'h7777);
    exp_pc = {exp_pc[15:10], 10'h200};
    flow(exp_pc, 1'b1, 1'b0);
    chk_vec(top, 33'h0);
    lng({1'b1, SAE_LONG_JUMP_ALWAYS, 10'h011}, 1'b0, 16'h0);
    flow(exp_pc, 1'b0, 1'b0);
  endtask
  task automatic t_logic;
    op(SAE_OP_ADD, 16'hf0f0);
    op(SAE_OP_AND, 16'h3c3c);
    chk_vec(top, 33'h3030);
    op(SAE_OP_COM, 16'h0);
    chk_vec(top, 33'h1ffffcfcf);
    chk_bit(stk.pop_ps, 1'b0);
  endtask
  // Mid-run reset, then 33 divide steps as division software issues them
  task automatic t_div;
    @(posedge clk) #1;
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    chk_vec(top, SAE_TOP_RST);
    chk_vec(areg, SAE_A_RST);
    op(SAE_OP_COM, 16'h0);
    op(SAE_OP_DIV, 16'h0);
    chk_vec(top, 33'h1fffffffe);
    chk_vec(areg, 16'h0001);
    op(SAE_OP_DIV, 16'h0002);
    chk_vec(top, 33'h0);
    chk_vec(areg, 16'h0002);
    repeat (31) op(SAE_OP_DIV, 16'h0);
    chk_vec(top, 33'h10000);
    chk_vec(areg, 16'h0);
  endtask
  task automatic complete_run;
    $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    chk_vec(pc, SAE_PC_RST);
    t_add;
    t_call;
    t_bc;
    t_bz;
    t_jmp;
    t_logic;
    t_div;
    complete_run;
  end
  initial begin
    #20000;
    n_mismatch++;
    complete_run;
  end
endmodule
`default_nettype wire
